// [logic/mdc_data_channel.sv]
// Eight channel cycle-stealing data channel engine
//
// Summary of operation
// - Eight independent channels, one controller each.
// - Each channel keeps its own item_countdown and transfer_pointer.
// - Each moved item decrements that channel's item_countdown.
// - Each moved item increments that channel's transfer_pointer.
// - Service by stolen cycles, channel address driven on the I/O bus.
// - Processor over the I/O bus, controllers over the channel bus.
// - Each channel is in initiate, data transfer or chaining mode.
// - Initiate reads the channel's two reserved words: address, count.
// - Fetched address loads pointer, fetched count loads countdown.
// - Exhausted countdown pulses block complete to that controller.
// - Chaining fetches new address from the current pointer location.
// - Chaining then fetches new count from the new address.
`timescale 1ns/1ps
module mdc_data_channel
   import mdc_pkg::*;
#(
   parameter int NCH = MDC_CHANNELS,
   parameter int AW = MDC_ADDR_W,
   parameter int DW = MDC_DATA_W
)
(
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_nrst,
   // I/O bus, cycle steal side
   output logic o_steal_req,
   output logic [AW-1:0] o_steal_addr,
   output logic o_steal_fetch,
   input wire logic i_steal_ack,
   input wire logic [DW-1:0] i_steal_rdata,
   // Channel bus, controller side
   input wire logic [NCH-1:0] i_init_req,
   input wire logic [NCH-1:0] i_chain_en,
   input wire logic [NCH-1:0] i_xfer_req,
   output logic [NCH-1:0] o_xfer_ack,
   output logic [NCH-1:0] o_block_done,
   output logic [NCH-1:0] o_ch_busy
);
   // Controller lines come from another board: two-stage synchronisers
   logic [NCH-1:0] init_s1_reg, init_s2_reg;
   logic [NCH-1:0] xfer_s1_reg, xfer_s2_reg;
   logic [NCH-1:0] chain_s1_reg, chain_s2_reg;

   always_ff @(posedge i_core_clk)
   begin
      if (!i_nrst)
      begin
         init_s1_reg <= '0;
         init_s2_reg <= '0;
         xfer_s1_reg <= '0;
         xfer_s2_reg <= '0;
         chain_s1_reg <= '0;
         chain_s2_reg <= '0;
      end
      else
      begin
         init_s1_reg <= i_init_req;
         init_s2_reg <= init_s1_reg;
         xfer_s1_reg <= i_xfer_req;
         xfer_s2_reg <= xfer_s1_reg;
         chain_s1_reg <= i_chain_en;
         chain_s2_reg <= chain_s1_reg;
      end
   end

   // Per channel state, kept apart for each controller
   logic [AW-1:0] ptr_reg [NCH]; // transfer_pointer
   logic [AW-1:0] ptr_next [NCH];
   logic [DW-1:0] cnt_reg [NCH]; // item_countdown
   logic [DW-1:0] cnt_next [NCH];
   mdc_mode_t mode_reg [NCH];
   mdc_mode_t mode_next [NCH];
   logic [NCH-1:0] active_reg, active_next;
   logic [NCH-1:0] pend_reg, pend_next;
   logic [NCH-1:0] done_reg, done_next;
   logic [NCH-1:0] ack_reg, ack_next;

   // Engine state
   mdc_state_t state_reg, state_next;
   logic [MDC_CH_W-1:0] cur_reg, cur_next;
   logic [AW-1:0] addr_reg, addr_next;
   logic fetch_reg, fetch_next;

   // Reserved word address for a channel's initiate pair
   function automatic logic [AW-1:0] init_word(
      input logic [MDC_CH_W-1:0] ch, input logic second);
      init_word = MDC_INIT_BASE + AW'({ch, second});
   endfunction

   // Service candidates: a fresh initiate or a latched transfer request
   logic [NCH-1:0] want;
   logic grant_any;
   logic [MDC_CH_W-1:0] grant_idx;

   always_comb
   begin
      for (int k = 0; k < NCH; k++)
         want[k] = (init_s2_reg[k] && !active_reg[k]) || pend_reg[k];
   end

   mdc_prio_arb #(.N(NCH), .W(MDC_CH_W)) mdc_prio_arb_inst (
      .i_req (want),
      .o_any (grant_any),
      .o_idx (grant_idx)
   );

   // Transfer request edges latch as pending until served
   logic [NCH-1:0] xfer_prev_reg, xfer_prev_next;
   logic [NCH-1:0] xfer_rise;
   assign xfer_rise = xfer_s2_reg & ~xfer_prev_reg;

   // Next state of channel table and engine
   always_comb
   begin
      for (int k = 0; k < NCH; k++)
      begin
         ptr_next[k] = ptr_reg[k];
         cnt_next[k] = cnt_reg[k];
         mode_next[k] = mode_reg[k];
      end
      active_next = active_reg;
      done_next = '0;
      ack_next = '0;
      xfer_prev_next = xfer_s2_reg;
      // Only active channels may queue items, in any mode
      pend_next = pend_reg | (xfer_rise & active_reg);
      state_next = state_reg;
      cur_next = cur_reg;
      addr_next = addr_reg;
      fetch_next = fetch_reg;

      unique case (state_reg)
         MDC_ST_IDLE:
         begin
            if (grant_any)
            begin
               cur_next = grant_idx;
               if (!active_reg[grant_idx])
               begin
                  // Service request puts the channel in initiate mode
                  mode_next[grant_idx] = MDC_MODE_INIT;
                  active_next[grant_idx] = 1'b1;
                  addr_next = init_word(grant_idx, 1'b0);
                  fetch_next = 1'b1;
                  state_next = MDC_ST_FETCH_ADDR;
               end
               else
               begin
                  // An edge arriving as the old one is served stays queued
                  pend_next[grant_idx] = xfer_rise[grant_idx];
                  addr_next = ptr_reg[grant_idx];
                  fetch_next = 1'b0;
                  state_next = MDC_ST_XFER;
               end
            end
         end
         MDC_ST_FETCH_ADDR:
         begin
            if (i_steal_ack)
            begin
               ptr_next[cur_reg] = AW'(i_steal_rdata);
               if (mode_reg[cur_reg] == MDC_MODE_CHAIN)
                  addr_next = AW'(i_steal_rdata);
               else
                  addr_next = init_word(cur_reg, 1'b1);
               state_next = MDC_ST_FETCH_CNT;
            end
         end
         MDC_ST_FETCH_CNT:
         begin
            if (i_steal_ack)
            begin
               cnt_next[cur_reg] = DW'(i_steal_rdata);
               // Chained block: data follows the count word
               if (mode_reg[cur_reg] == MDC_MODE_CHAIN)
                  ptr_next[cur_reg] = ptr_reg[cur_reg] + AW'(1);
               mode_next[cur_reg] = MDC_MODE_XFER;
               // A zero count needs no items at all
               if (i_steal_rdata == '0)
                  state_next = MDC_ST_DONE;
               else
                  state_next = MDC_ST_IDLE;
               fetch_next = 1'b0;
            end
         end
         MDC_ST_XFER:
         begin
            if (i_steal_ack)
            begin
               ack_next[cur_reg] = 1'b1;
               ptr_next[cur_reg] = ptr_reg[cur_reg] + AW'(1);
               cnt_next[cur_reg] = cnt_reg[cur_reg] - DW'(1);
               if (cnt_reg[cur_reg] == DW'(1))
                  state_next = MDC_ST_DONE;
               else
                  state_next = MDC_ST_IDLE;
            end
         end
         MDC_ST_DONE:
         begin
            // Every exhausted block is reported, chained or not
            done_next[cur_reg] = 1'b1;
            if (chain_s2_reg[cur_reg])
            begin
               // Next descriptor sits at the current pointer
               mode_next[cur_reg] = MDC_MODE_CHAIN;
               addr_next = ptr_reg[cur_reg];
               fetch_next = 1'b1;
               state_next = MDC_ST_FETCH_ADDR;
            end
            else
            begin
               active_next[cur_reg] = 1'b0;
               pend_next[cur_reg] = 1'b0;
               state_next = MDC_ST_IDLE;
            end
         end
         default:
            state_next = MDC_ST_IDLE;
      endcase
   end

   // Register every group of state
   always_ff @(posedge i_core_clk)
   begin
      if (!i_nrst)
      begin
         for (int k = 0; k < NCH; k++)
         begin
            ptr_reg[k] <= MDC_PTR_RESET;
            cnt_reg[k] <= MDC_CNT_RESET;
            mode_reg[k] <= MDC_MODE_INIT;
         end
         active_reg <= '0;
         pend_reg <= '0;
         done_reg <= '0;
         ack_reg <= '0;
         xfer_prev_reg <= '0;
         state_reg <= MDC_ST_IDLE;
         cur_reg <= '0;
         addr_reg <= '0;
         fetch_reg <= 1'b0;
      end
      else
      begin
         for (int k = 0; k < NCH; k++)
         begin
            ptr_reg[k] <= ptr_next[k];
            cnt_reg[k] <= cnt_next[k];
            mode_reg[k] <= mode_next[k];
         end
         active_reg <= active_next;
         pend_reg <= pend_next;
         done_reg <= done_next;
         ack_reg <= ack_next;
         xfer_prev_reg <= xfer_prev_next;
         state_reg <= state_next;
         cur_reg <= cur_next;
         addr_reg <= addr_next;
         fetch_reg <= fetch_next;
      end
   end

   // Bus side drives: request while any memory cycle is outstanding
   assign o_steal_req = (state_reg == MDC_ST_FETCH_ADDR) ||
      (state_reg == MDC_ST_FETCH_CNT) ||
      (state_reg == MDC_ST_XFER);
   assign o_steal_addr = addr_reg;
   assign o_steal_fetch = fetch_reg;
   // Channel bus drives
   assign o_xfer_ack = ack_reg;
   assign o_block_done = done_reg;
   assign o_ch_busy = active_reg;
endmodule

// [logic/mdc_pkg.sv]
// Shared constants and types for the multi-channel data channel block
package mdc_pkg;
   localparam int MDC_CHANNELS = 8;
   localparam int MDC_ADDR_W = 16;
   localparam int MDC_DATA_W = 16;
   localparam int MDC_CH_W = 3;
   // Base of the reserved word pairs: channel n uses base+2n and base+2n+1
   localparam logic [15:0] MDC_INIT_BASE = 16'h0020;
   localparam logic [15:0] MDC_PTR_RESET = 16'h0000;
   localparam logic [15:0] MDC_CNT_RESET = 16'h0000;
   // Channel modes
   typedef enum logic [2:0] {
      MDC_MODE_INIT = 3'h1,
      MDC_MODE_XFER = 3'h2,
      MDC_MODE_CHAIN = 3'h4
   } mdc_mode_t;
   // Engine states
   typedef enum logic [4:0] {
      MDC_ST_IDLE = 5'h01,
      MDC_ST_FETCH_ADDR = 5'h02,
      MDC_ST_FETCH_CNT = 5'h04,
      MDC_ST_XFER = 5'h08,
      MDC_ST_DONE = 5'h10
   } mdc_state_t;
endpackage

// [logic/mdc_prio_arb.sv]
// Fixed priority picker, lowest channel number wins
`timescale 1ns/1ps
module mdc_prio_arb
   import mdc_pkg::*;
#(
   parameter int N = 8,
   parameter int W = 3
)
(
   // Requests
   input wire logic [N-1:0] i_req,
   // Grant
   output logic o_any,
   output logic [W-1:0] o_idx
);
   // Scan from the top so the lowest set bit is the last written
   always_comb
   begin
      o_any = 1'b0;
      o_idx = '0;
      for (int k = N - 1; k >= 0; k--)
      begin
         if (i_req[k])
         begin
            o_any = 1'b1;
            o_idx = W'(k);
         end
      end
   end
endmodule

// [tb/mdc_data_channel_test.sv]
// Self-checking bench for the data channel engine
`timescale 1ns/1ps
module mdc_data_channel_test;
   import mdc_pkg::*;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] init_r = 8'h00;
   logic [7:0] chain_r = 8'h00;
   logic [7:0] xreq = 8'h00;
   logic [3:0] lat = 4'h0;
   logic req, fetch, ack;
   logic [15:0] addr, rdata;
   logic [7:0] xack, done, busy;
   logic [7:0] done_seen = 8'h00;
   logic [7:0] ack_seen = 8'h00;
   int bad_count = 0;
   int samples_checked = 0;
   mdc_data_channel mdc_data_channel_inst (.i_core_clk(clk), .i_nrst(nrst),
      .o_steal_req(req), .o_steal_addr(addr), .o_steal_fetch(fetch),
      .i_steal_ack(ack), .i_steal_rdata(rdata), .i_init_req(init_r),
      .i_chain_en(chain_r), .i_xfer_req(xreq), .o_xfer_ack(xack),
      .o_block_done(done), .o_ch_busy(busy));
   mdc_mem_model mem_inst (.i_clk(clk), .i_req(req), .i_addr(addr),
      .i_fetch(fetch), .i_lat(lat), .o_ack(ack), .o_rdata(rdata));
   initial
      forever #20 clk = ~clk;
   // Sticky capture, since ack and done last one cycle
   always @(posedge clk)
   begin
      done_seen <= done_seen | done;
      ack_seen <= ack_seen | xack;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic print_verdict();
      $display("checked %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Bounded wait on ack (0), done (1) or busy (2) of one channel
   task automatic wait_hi(input int sel, input int ch);
      int i;
      logic b;
      for (i = 0; i < 99; i++)
      begin
         b = sel == 0 ? ack_seen[ch] : sel == 1 ? done_seen[ch] : busy[ch];
         if (b === 1'b1)
            break;
         tick(1);
      end
      if (i == 99)
      begin
         chk(b, 1'b1);
         print_verdict();
      end
   endtask
   task automatic qchk(input logic [15:0] a);
      logic [15:0] v;
      v = mem_inst.wq.size() ? mem_inst.wq.pop_front() : 16'hFFFF;
      chk(v, a);
   endtask
   task automatic start(input int ch, input logic [15:0] a,
      input logic [15:0] n);
      mem_inst.mem[MDC_INIT_BASE + 16'(2 * ch)] = a;
      mem_inst.mem[MDC_INIT_BASE + 16'(2 * ch + 1)] = n;
      done_seen = 8'h00;
      init_r[ch] = 1'b1;
      wait_hi(2, ch);
      init_r[ch] = 1'b0;
   endtask
   task automatic item(input int ch);
      ack_seen = 8'h00;
      xreq[ch] = 1'b1;
      wait_hi(0, ch);
      xreq[ch] = 1'b0;
      tick(2);
   endtask
   task automatic blk(input int ch, input logic [15:0] a,
      input logic [15:0] n);
      int k;
      start(ch, a, n);
      for (k = 0; k < n; k++)
      begin
         chk(done_seen[ch], 1'b0);
         item(ch);
         qchk(a + 16'(k));
      end
      wait_hi(1, ch);
      chk(busy[ch], 1'b0);
   endtask
   // Interleaved channels keep separate pointers
   task automatic two_ch();
      start(1, 16'h0400, 16'h0002);
      start(6, 16'h0500, 16'h0002);
      repeat (2)
      begin
         item(1);
         item(6);
      end
      wait_hi(1, 6);
      chk(done_seen, 8'h42);
      qchk(16'h0400);
      qchk(16'h0500);
      qchk(16'h0401);
      qchk(16'h0501);
   endtask
   // Simultaneous requests, lower channel first
   task automatic prio();
      start(2, 16'h0900, 16'h0001);
      start(5, 16'h0A00, 16'h0001);
      ack_seen = 8'h00;
      xreq = 8'h24;
      wait_hi(0, 2);
      chk(ack_seen, 8'h04);
      wait_hi(0, 5);
      xreq = 8'h00;
      qchk(16'h0900);
      qchk(16'h0A00);
   endtask
   // Chained block through a link word after the data
   task automatic chain();
      mem_inst.mem[16'h0601] = 16'h0700;
      mem_inst.mem[16'h0700] = 16'h0002;
      chain_r[3] = 1'b1;
      start(3, 16'h0600, 16'h0001);
      item(3);
      wait_hi(1, 3);
      tick(8);
      chain_r[3] = 1'b0;
      chk(busy[3], 1'b1);
      item(3);
      item(3);
      qchk(16'h0600);
      qchk(16'h0701);
      qchk(16'h0702);
   endtask
   initial
   begin
      tick(10);
      nrst = 1'b1;
      tick(2);
      blk(0, 16'h0100, 16'h0003);
      lat = 4'h3;
      blk(7, 16'h0300, 16'h0001);
      // Zero count: block completes with no data cycle
      blk(4, 16'h0800, 16'h0000);
      lat = 4'h1;
      two_ch();
      prio();
      chain();
      print_verdict();
   end
endmodule

// [tb/mdc_dc_asserts.sv]
// Port protocol checker for the data channel engine
`timescale 1ns/1ps
module mdc_dc_asserts
   import mdc_pkg::*;
#(
   parameter int NCH = 8,
   parameter int AW = 16,
   parameter int DW = 16
)
(
   // Clock, reset and steal bus
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic o_steal_req,
   input wire logic [AW-1:0] o_steal_addr,
   input wire logic o_steal_fetch,
   input wire logic i_steal_ack,
   // Channel bus
   input wire logic [NCH-1:0] o_xfer_ack,
   input wire logic [NCH-1:0] o_block_done,
   input wire logic [NCH-1:0] o_ch_busy
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);
   // Taken data and fetch cycles
   wire logic dat = o_steal_req && i_steal_ack && !o_steal_fetch;
   wire logic fet = o_steal_req && i_steal_ack && o_steal_fetch;
   property p_hold;
      o_steal_req && !i_steal_ack |=> o_steal_req && $stable(o_steal_addr)
         && $stable(o_steal_fetch);
   endproperty
   a_hold: assert property (p_hold)
      else $error("steal request changed before ack");
   property p_gap;
      dat |=> !o_steal_req;
   endproperty
   a_gap: assert property (p_gap)
      else $error("no idle cycle after data cycle");
   property p_ack_after;
      dat |=> $onehot(o_xfer_ack);
   endproperty
   a_ack_after: assert property (p_ack_after)
      else $error("item ack missing after data cycle");
   property p_ack_cause;
      |o_xfer_ack |-> $past(dat);
   endproperty
   a_ack_cause: assert property (p_ack_cause)
      else $error("item ack without data cycle");
   property p_one;
      $onehot0(o_xfer_ack) && $onehot0(o_block_done);
   endproperty
   a_one: assert property (p_one)
      else $error("two channels served at once");
   property p_pulse;
      |o_block_done |=> !(|o_block_done);
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("block done longer than one cycle");
   property p_busy;
      !(|(o_xfer_ack & ~o_ch_busy));
   endproperty
   a_busy: assert property (p_busy)
      else $error("item ack on idle channel");
   // Init address word is followed at once by the count word
   property p_pair;
      fet && o_steal_addr[AW-1:4] == MDC_INIT_BASE[15:4] && !o_steal_addr[0]
         |=> o_steal_req && o_steal_fetch
         && o_steal_addr == $past(o_steal_addr) + 16'h1;
   endproperty
   a_pair: assert property (p_pair)
      else $error("count word fetch out of order");
endmodule
bind mdc_data_channel mdc_dc_asserts #(.NCH(NCH), .AW(AW), .DW(DW))
   chk_inst (
      .i_core_clk (i_core_clk),
      .i_nrst (i_nrst),
      .o_steal_req (o_steal_req),
      .o_steal_addr (o_steal_addr),
      .o_steal_fetch (o_steal_fetch),
      .i_steal_ack (i_steal_ack),
      .o_xfer_ack (o_xfer_ack),
      .o_block_done (o_block_done),
      .o_ch_busy (o_ch_busy)
   );

// [tb/mdc_mem_model.sv]
// Memory partner answering stolen cycles after a chosen wait
`timescale 1ns/1ps
module mdc_mem_model
(
   // Steal bus, seen from memory
   input wire logic i_clk,
   input wire logic i_req,
   input wire logic [15:0] i_addr,
   input wire logic i_fetch,
   input wire logic [3:0] i_lat,
   output logic o_ack,
   output logic [15:0] o_rdata
);
   logic [15:0] mem [logic [15:0]];
   logic [15:0] wq [$];
   int cnt = 0;
   initial o_ack = 1'b0;
   initial o_rdata = 16'hA5A5;
   // Read data toggles every cycle except on a fetch ack, so stale words never look valid
   always @(posedge i_clk)
   begin
      o_rdata <= ~o_rdata;
      o_ack <= 1'b0;
      cnt <= i_req ? cnt + 1 : 0;
      if (i_req && !o_ack && cnt >= i_lat)
      begin
         o_ack <= 1'b1;
         cnt <= 0;
         if (i_fetch)
            o_rdata <= mem.exists(i_addr) ? mem[i_addr] : 16'hDEAD;
         else
            wq.push_back(i_addr);
      end
   end
endmodule
